/* logic/tracker_mode_command_setup.sv */
// tracker_mode_command_setup: tracker end, decodes command words into mode,
// raster and track settings and steps the raster.
// assumes star_present and tlm_frame are synchronous to sys_clk.
`timescale 1ns/1ps
module tracker_mode_command_setup #(
    parameter int DWELL = tracker_cmd_pkg::DWELL_CYCLES
) (
    input  wire logic                                sys_clk,
    input  wire logic                                resetn,
    tracker_cmd_if.tracker                           link,
    input  wire logic                                star_present,
    input  wire logic                                tlm_frame,
    output logic [1:0]                               system_mode_field,
    output logic                                     track_enable_flag,
    output logic                                     underlap_overlap_select,
    output logic                                     track_scan_rate_select,
    output logic [1:0]                               acquisition_threshold_field,
    output logic [tracker_cmd_pkg::DEFL_W-1:0]       defl_x,
    output logic [tracker_cmd_pkg::DEFL_W-1:0]       defl_y,
    output logic [tracker_cmd_pkg::FINE_W-1:0]       fine_x,
    output logic [tracker_cmd_pkg::FINE_W-1:0]       fine_y,
    output logic                                     tracking,
    output logic                                     mag_refresh,
    output logic                                     end_of_scan_line
);
    localparam int CW = tracker_cmd_pkg::COARSE_W;
    localparam int FW = tracker_cmd_pkg::FINE_W;
    localparam int SW = tracker_cmd_pkg::STEP_W;
    localparam int IW = tracker_cmd_pkg::IDX_W;
    localparam int DW = tracker_cmd_pkg::DEFL_W;

    typedef enum logic [1:0] {ST_PRIMARY, ST_SEARCH, ST_TRACK} scan_state_t;

    // command capture
    logic                                cmd_reg, cmd_next;
    logic [tracker_cmd_pkg::CMD_W-1:0]   word_reg, word_next;
    // active settings
    logic [1:0]    mode_reg, mode_next;
    logic          te_reg, te_next, ulol_reg, ulol_next, tsr_reg, tsr_next;
    logic [1:0]    thd_reg, thd_next;
    logic [CW-1:0] xc_reg, xc_next, yc_reg, yc_next;
    logic [FW-1:0] xf_reg, xf_next, yf_reg, yf_next;
    logic [SW-1:0] step_reg, step_next;
    // deferred coarse settings
    logic [CW-1:0] px_reg, px_next, py_reg, py_next;
    logic [SW-1:0] pstep_reg, pstep_next;
    logic          pline_reg, pline_next, pframe_reg, pframe_next;
    // raster
    scan_state_t   state_reg, state_next;
    logic [IW-1:0] xi_reg, xi_next, yi_reg, yi_next;
    logic [31:0]   dwell_reg, dwell_next;
    logic          mag_reg, mag_next, eol_reg, eol_next;
    logic          trk_reg, trk_next;
    logic [DW-1:0] dx_reg, dx_next, dy_reg, dy_next;

    // word fields
    logic [1:0]    w_mode;
    logic [CW-1:0] w_xc, w_yc;
    logic [FW-1:0] w_xf, w_yf;
    logic [SW-1:0] w_step;
    logic [IW-1:0] span;
    logic          dwell_end, camera, may_track, restart;

    // capture the word whole so no update mixes two words
    always_comb begin
        cmd_next  = link.cmd_valid;
        word_next = link.cmd_valid ? link.serial_command_word : word_reg;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cmd_reg  <= 1'b0;
            word_reg <= tracker_cmd_pkg::CMD_RESET;
        end else begin
            cmd_reg  <= cmd_next;
            word_reg <= word_next;
        end
    end

    // settings, deferred updates and raster stepping share one next-state block
    always_comb begin
        w_mode = word_reg[tracker_cmd_pkg::MODE_LSB +: 2];
        w_xc   = word_reg[tracker_cmd_pkg::XC_LSB +: CW];
        w_yc   = word_reg[tracker_cmd_pkg::YC_LSB +: CW];
        w_xf   = word_reg[tracker_cmd_pkg::XF_LSB +: FW];
        w_yf   = word_reg[tracker_cmd_pkg::YF_LSB +: FW];
        w_step = word_reg[tracker_cmd_pkg::STEP_LSB +: SW];
        camera = tracker_cmd_pkg::decode_mode(mode_reg) == tracker_cmd_pkg::SYS_CAMERA;
        may_track = (tracker_cmd_pkg::decode_mode(mode_reg) == tracker_cmd_pkg::SYS_SEARCH) || (camera && te_reg);
        span   = {step_reg, 1'b0};  // 2*steps+1 positions
        mode_next = mode_reg;   te_next = te_reg;     ulol_next = ulol_reg;
        tsr_next  = tsr_reg;    thd_next = thd_reg;   step_next = step_reg;
        xc_next   = xc_reg;     yc_next = yc_reg;     xf_next = xf_reg;   yf_next = yf_reg;
        px_next   = px_reg;     py_next = py_reg;     pstep_next = pstep_reg;
        pline_next = pline_reg; pframe_next = pframe_reg;
        state_next = state_reg; xi_next = xi_reg;     yi_next = yi_reg;
        dwell_next = dwell_reg;
        mag_next  = 1'b0;
        eol_next  = 1'b0;
        restart   = 1'b0;
        // dwell: fixed timer in search and track, telemetry frame in camera mode
        dwell_end = 1'b0;
        if (state_reg != ST_PRIMARY) begin
            if (camera) begin
                dwell_end  = tlm_frame;
                dwell_next = 32'h0000_0000;
            end else if (dwell_reg >= 32'(DWELL - 1)) begin
                dwell_end  = 1'b1;
                dwell_next = 32'h0000_0000;
            end else begin
                dwell_next = dwell_reg + 32'h0000_0001;
            end
        end
        // raster stepping
        if (state_reg == ST_SEARCH) begin
            if (link.continue_search) begin
                if (yi_reg + 6'h02 > span) begin
                    yi_next = '0;
                    xi_next = '0;
                end else begin
                    yi_next = yi_reg + 6'h02;
                end
            end else if (dwell_end) begin
                mag_next = 1'b1;
                if (may_track && star_present) begin
                    state_next = ST_TRACK;
                end else if (xi_reg >= span) begin
                    // zero steps leaves span at zero, so the spot never moves
                    xi_next  = '0;
                    eol_next = 1'b1;
                    if (pline_reg) begin
                        xc_next    = px_reg;
                        step_next  = pstep_reg;
                        pline_next = 1'b0;
                    end
                    if (yi_reg >= span) begin
                        yi_next = '0;
                        if (pframe_reg) begin
                            yc_next     = py_reg;
                            step_next   = pstep_reg;
                            pframe_next = 1'b0;
                        end
                    end else begin
                        yi_next = yi_reg + 6'h01;
                    end
                end else begin
                    xi_next = xi_reg + 6'h01;
                end
            end
        end else if (state_reg == ST_TRACK) begin
            // spot holds while tracking, also when the star drops out
            if (dwell_end)
                mag_next = 1'b1;
            if (link.continue_search) begin
                state_next = ST_SEARCH;
                if (pline_reg) begin
                    xc_next = px_reg;
                    step_next = pstep_reg;
                    pline_next = 1'b0;
                end
                if (pframe_reg) begin
                    yc_next = py_reg;
                    pframe_next = 1'b0;
                end
                yi_next = (yi_reg + 6'h02 > span) ? 6'h00 : yi_reg + 6'h02;
            end
        end
        // command acceptance, one cycle after the word arrives
        if (cmd_reg) begin
            xf_next   = w_xf;
            yf_next   = w_yf;
            ulol_next = word_reg[tracker_cmd_pkg::ULOL_BIT];
            tsr_next  = word_reg[tracker_cmd_pkg::TSR_BIT];
            if (tracker_cmd_pkg::decode_mode(w_mode) == tracker_cmd_pkg::SYS_PRIMARY) begin
                // steps, track enable and threshold are left as they were; tracking drops with the state
                mode_next  = w_mode;
                xc_next    = w_xc;
                yc_next    = w_yc;
                state_next = ST_PRIMARY;
                pline_next = 1'b0;
                pframe_next = 1'b0;
            end else if (tracker_cmd_pkg::decode_mode(w_mode) != tracker_cmd_pkg::decode_mode(mode_reg) ||
                         word_reg[tracker_cmd_pkg::TE_BIT] != te_reg) begin
                restart = 1'b1;
            end else begin
                thd_next    = word_reg[tracker_cmd_pkg::THD_LSB +: 2];
                px_next     = w_xc;
                py_next     = w_yc;
                pstep_next  = w_step;
                pline_next  = 1'b1;
                pframe_next = 1'b1;
            end
        end
        // new search or camera mode or tracking state: take every field and start the raster over
        if (restart) begin
            mode_next   = w_mode;
            te_next     = word_reg[tracker_cmd_pkg::TE_BIT];
            thd_next    = word_reg[tracker_cmd_pkg::THD_LSB +: 2];
            xc_next     = w_xc;
            yc_next     = w_yc;
            step_next   = w_step;
            pline_next  = 1'b0;
            pframe_next = 1'b0;
            xi_next     = '0;
            yi_next     = '0;
            dwell_next  = 32'h0000_0000;
            state_next  = ST_SEARCH;
        end
        // deflection from two's complement start plus x raster offset, minus y raster offset
        if (tracker_cmd_pkg::is_neg_zero(xc_reg))
            dx_next = tracker_cmd_pkg::DEFL_LIMIT;
        else
            dx_next = DW'({{(DW-CW){xc_reg[CW-1]}}, xc_reg} + {{(DW-IW){1'b0}}, xi_reg});
        if (tracker_cmd_pkg::is_neg_zero(yc_reg))
            dy_next = tracker_cmd_pkg::DEFL_LIMIT;
        else
            dy_next = DW'({{(DW-CW){yc_reg[CW-1]}}, yc_reg} - {{(DW-IW){1'b0}}, yi_reg});
        // own flop so the tracking pin is glitch free, same timing as the state
        trk_next = state_next == ST_TRACK;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mode_reg <= tracker_cmd_pkg::MODE_PRIMARY;
            te_reg <= 1'b0;  ulol_reg <= 1'b0;  tsr_reg <= 1'b0;  thd_reg <= 2'h0;
            xc_reg <= '0;    yc_reg <= '0;      xf_reg <= '0;     yf_reg <= '0;
            step_reg <= '0;  px_reg <= '0;      py_reg <= '0;     pstep_reg <= '0;
            pline_reg <= 1'b0;
            pframe_reg <= 1'b0;
            state_reg <= ST_PRIMARY;
            xi_reg <= '0;
            yi_reg <= '0;
            dwell_reg <= 32'h0000_0000;
            mag_reg <= 1'b0;
            eol_reg <= 1'b0;
            trk_reg <= 1'b0;
            dx_reg <= '0;
            dy_reg <= '0;
        end else begin
            mode_reg <= mode_next;
            te_reg <= te_next;  ulol_reg <= ulol_next;  tsr_reg <= tsr_next;  thd_reg <= thd_next;
            xc_reg <= xc_next;  yc_reg <= yc_next;      xf_reg <= xf_next;    yf_reg <= yf_next;
            step_reg <= step_next;  px_reg <= px_next;  py_reg <= py_next;    pstep_reg <= pstep_next;
            pline_reg <= pline_next;
            pframe_reg <= pframe_next;
            state_reg <= state_next;
            xi_reg <= xi_next;
            yi_reg <= yi_next;
            dwell_reg <= dwell_next;
            mag_reg <= mag_next;
            eol_reg <= eol_next;
            trk_reg <= trk_next;
            dx_reg <= dx_next;
            dy_reg <= dy_next;
        end
    end

    assign system_mode_field           = mode_reg;
    assign track_enable_flag           = te_reg;
    assign underlap_overlap_select     = ulol_reg;
    assign track_scan_rate_select      = tsr_reg;
    assign acquisition_threshold_field = thd_reg;
    assign defl_x                      = dx_reg;
    assign defl_y                      = dy_reg;
    assign fine_x                      = xf_reg;
    assign fine_y                      = yf_reg;
    assign tracking                    = trk_reg;
    assign mag_refresh                 = mag_reg;
    assign end_of_scan_line            = eol_reg;
endmodule // tracker_mode_command_setup

/* logic/tracker_cmd_pkg.sv */
// tracker_cmd_pkg: command word layout, mode codes, timing counts shared by both ends.
// assumes a 50 MHz sys_clk on both ends and one command word per transfer.
package tracker_cmd_pkg;
    localparam int CMD_W       = 32;
    localparam int COARSE_W    = 6;
    localparam int FINE_W      = 4;
    localparam int STEP_W      = 5;
    localparam int IDX_W       = 6;
    localparam int DEFL_W      = 8;
    // field positions in the command word
    localparam int XC_LSB      = 0;
    localparam int XF_LSB      = 6;
    localparam int YC_LSB      = 10;
    localparam int YF_LSB      = 16;
    localparam int STEP_LSB    = 20;
    localparam int ULOL_BIT    = 25;
    localparam int TSR_BIT     = 26;
    localparam int THD_LSB     = 27;
    localparam int TE_BIT      = 29;
    localparam int MODE_LSB    = 30;
    // mode codes of the two-bit system mode field
    localparam logic [1:0] MODE_PRIMARY = 2'h0;
    localparam logic [1:0] MODE_SEARCH  = 2'h1;
    localparam logic [1:0] MODE_CAMERA  = 2'h2;
    localparam logic [DEFL_W-1:0] DEFL_LIMIT = 8'h80;
    localparam logic [CMD_W-1:0]  CMD_RESET  = 32'h0000_0000;
    // timing
    localparam int     CLK_HZ       = 50_000_000;
    localparam real    DWELL_MS     = 2.4;
    localparam int     DWELL_CYCLES = int'(DWELL_MS * CLK_HZ / 1000.0);
    localparam real    SPACING_S    = 1.0;
    localparam int     SPACING_CYCLES = int'(SPACING_S * CLK_HZ);

    typedef enum logic [1:0] {SYS_PRIMARY, SYS_SEARCH, SYS_CAMERA} sys_mode_t;

    // every code maps to a normal mode, no forbidden pattern
    function automatic sys_mode_t decode_mode(input logic [1:0] code);
        if (code[1])
            return SYS_CAMERA;
        else if (code[0])
            return SYS_SEARCH;
        else
            return SYS_PRIMARY;
    endfunction

    // negative zero: sign set, magnitude bits clear
    function automatic logic is_neg_zero(input logic [COARSE_W-1:0] c);
        return c == {1'b1, {(COARSE_W-1){1'b0}}};
    endfunction
endpackage

/* logic/tracker_cmd_if.sv */
// tracker_cmd_if: command link between sequencer and tracker command logic.
// assumes both ends on sys_clk; strobes are one-cycle pulses.
`timescale 1ns/1ps
interface tracker_cmd_if;
    logic                                 cmd_valid;
    logic [tracker_cmd_pkg::CMD_W-1:0]    serial_command_word;
    logic                                 continue_search;

    modport commander (output cmd_valid, output serial_command_word, output continue_search);
    modport tracker   (input cmd_valid, input serial_command_word, input continue_search);
endinterface

/* logic/tracker_commander.sv */
// tracker_commander: sequencer end, paces and screens command words.
// assumes user requests are single-cycle strobes on sys_clk.
`timescale 1ns/1ps
module tracker_commander #(
    parameter int SPACING = tracker_cmd_pkg::SPACING_CYCLES
) (
    input  wire logic                              sys_clk,
    input  wire logic                              resetn,
    tracker_cmd_if.commander                       link,
    input  wire logic                              req_valid,
    input  wire logic [tracker_cmd_pkg::CMD_W-1:0] req_word,
    input  wire logic                              req_continue,
    output logic                                   busy,
    output logic                                   rejected
);
    logic [31:0]                         gap_reg, gap_next;
    logic                                valid_reg, valid_next;
    logic [tracker_cmd_pkg::CMD_W-1:0]   word_reg, word_next;
    logic                                cont_reg, cont_next;
    logic                                rej_reg, rej_next;
    logic                                bad;

    // screen and pace requests; a refused request is dropped, not queued
    always_comb begin
        bad = tracker_cmd_pkg::is_neg_zero(req_word[tracker_cmd_pkg::XC_LSB +: tracker_cmd_pkg::COARSE_W]) ||
              tracker_cmd_pkg::is_neg_zero(req_word[tracker_cmd_pkg::YC_LSB +: tracker_cmd_pkg::COARSE_W]);
        gap_next   = (gap_reg != 32'h0000_0000) ? gap_reg - 32'h0000_0001 : gap_reg;
        valid_next = 1'b0;
        word_next  = word_reg;
        rej_next   = 1'b0;
        cont_next  = req_continue;
        if (req_valid) begin
            if (bad || gap_reg != 32'h0000_0000) begin
                rej_next = 1'b1;
            end else begin
                valid_next = 1'b1;
                word_next  = req_word;
                gap_next   = 32'(SPACING);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gap_reg   <= 32'h0000_0000;
            valid_reg <= 1'b0;
            word_reg  <= tracker_cmd_pkg::CMD_RESET;
            cont_reg  <= 1'b0;
            rej_reg   <= 1'b0;
        end else begin
            gap_reg   <= gap_next;
            valid_reg <= valid_next;
            word_reg  <= word_next;
            cont_reg  <= cont_next;
            rej_reg   <= rej_next;
        end
    end

    assign link.cmd_valid           = valid_reg;
    assign link.serial_command_word = word_reg;
    assign link.continue_search     = cont_reg;
    assign busy                     = gap_reg != 32'h0000_0000;
    assign rejected                 = rej_reg;
endmodule // tracker_commander

/* test/tracker_link_sva.sv */
// tracker_link_sva: concurrent checks on the command link between the two ends.
// assumes sys_clk and resetn of the link's domain; instantiated beside the interface.
`timescale 1ns/1ps
module tracker_link_sva #(
    parameter int SPACING = tracker_cmd_pkg::SPACING_CYCLES
) (
    input wire logic                              sys_clk,
    input wire logic                              resetn,
    input wire logic                              cmd_valid,
    input wire logic [tracker_cmd_pkg::CMD_W-1:0] serial_command_word,
    input wire logic                              continue_search
);
    int gap_reg;
    int gap_next;

    // cycles since the last word, saturating so the first word after reset is legal
    always_comb begin
        gap_next = cmd_valid ? 1 : ((gap_reg < SPACING) ? gap_reg + 1 : gap_reg);
    end

    // registers the gap count only
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gap_reg <= SPACING;
        end else begin
            gap_reg <= gap_next;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    AST_VALID_PULSE: assert property (cmd_valid |=> !cmd_valid)
        else $error("word strobe longer than one cycle");
    AST_SPACING: assert property (cmd_valid |-> gap_reg >= SPACING)
        else $error("words closer than the spacing");
    AST_QUIET_AFTER: assert property (cmd_valid |=> (!cmd_valid) [*8])
        else $error("word follows too soon after another");
    AST_NEGZERO_X: assert property (cmd_valid |-> serial_command_word[5:0] != 6'h20)
        else $error("negative zero in x start sent");
    AST_NEGZERO_Y: assert property (cmd_valid |-> serial_command_word[15:10] != 6'h20)
        else $error("negative zero in y start sent");
    AST_WORD_HELD: assert property (!cmd_valid |-> $stable(serial_command_word))
        else $error("word changed without a strobe");
    AST_WORD_SETTLES: assert property (cmd_valid |=> $stable(serial_command_word) [*3])
        else $error("word not held after its strobe");
    AST_CONT_PULSE: assert property (continue_search |=> !continue_search)
        else $error("continue strobe longer than one cycle");

    // main traffic kinds
    COV_CAMERA: cover property (cmd_valid && serial_command_word[31]);
    COV_SEARCH: cover property (cmd_valid && serial_command_word[31:30] == 2'h1);
    COV_CONTINUE: cover property (continue_search);
endmodule // tracker_link_sva

/* test/tracker_mode_command_setup_tb_top.sv */
// tracker_mode_command_setup_tb_top: both ends on one link, a bare tracker on a second link.
// assumes package and interface compiled first; 50 MHz clock, shortened spacing and dwell.
`timescale 1ns/1ps
module tracker_mode_command_setup_tb_top;
    localparam int SPC = 30;
    localparam int DWL = 20;
    typedef struct packed {logic [31:0] w; logic [7:0] e;} row_t;
    logic        sys_clk = 1'h0;
    logic        resetn = 1'h0;
    logic        req_valid = 1'h0;
    logic [31:0] req_word = 32'h0000_0000;
    logic        req_continue = 1'h0;
    logic        star_present = 1'h0;
    logic        tlm_frame = 1'h0;
    logic        busy, rejected, track_enable_flag, underlap_overlap_select, track_scan_rate_select;
    logic        tracking, mag_refresh, end_of_scan_line;
    logic [1:0]  system_mode_field, acquisition_threshold_field;
    logic [7:0]  defl_x, defl_y, defl_x_b, defl_y_b;
    logic [3:0]  fine_x, fine_y;
    wire  [7:0]  settings = {1'h0, system_mode_field[1], system_mode_field[1] ? 1'h0 : system_mode_field[0],
                             track_enable_flag, underlap_overlap_select, track_scan_rate_select,
                             acquisition_threshold_field};
    int          n_mismatch = 0;
    int          checks = 0;
    int          cyc = 0;
    int          n;
    int          e;
    row_t        rows [4];

    tracker_cmd_if link();
    tracker_cmd_if link2();

    tracker_commander #(.SPACING(SPC)) i_tracker_commander (.sys_clk(sys_clk), .resetn(resetn), .link(link),
        .req_valid(req_valid), .req_word(req_word), .req_continue(req_continue), .busy(busy), .rejected(rejected));
    tracker_mode_command_setup #(.DWELL(DWL)) i_tracker_mode_command_setup (.sys_clk(sys_clk), .resetn(resetn),
        .link(link), .star_present(star_present), .tlm_frame(tlm_frame), .system_mode_field(system_mode_field),
        .track_enable_flag(track_enable_flag), .underlap_overlap_select(underlap_overlap_select),
        .track_scan_rate_select(track_scan_rate_select), .acquisition_threshold_field(acquisition_threshold_field),
        .defl_x(defl_x), .defl_y(defl_y), .fine_x(fine_x), .fine_y(fine_y), .tracking(tracking),
        .mag_refresh(mag_refresh), .end_of_scan_line(end_of_scan_line));
    // second tracker fed straight by the bench, to send what a good commander never would
    tracker_mode_command_setup #(.DWELL(DWL)) i_tracker_mode_command_setup_b (.sys_clk(sys_clk),
        .resetn(resetn), .link(link2), .star_present(1'h0), .tlm_frame(1'h0), .system_mode_field(),
        .track_enable_flag(), .underlap_overlap_select(), .track_scan_rate_select(),
        .acquisition_threshold_field(), .defl_x(defl_x_b), .defl_y(defl_y_b), .fine_x(), .fine_y(),
        .tracking(), .mag_refresh(), .end_of_scan_line());
    tracker_link_sva #(.SPACING(SPC)) i_tracker_link_sva (.sys_clk(sys_clk), .resetn(resetn),
        .cmd_valid(link.cmd_valid), .serial_command_word(link.serial_command_word),
        .continue_search(link.continue_search));

    always #10 sys_clk = ~sys_clk;

    // hang guard, well above the few hundred cycles the sequence needs
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    function automatic logic [31:0] mk(input logic [1:0] m, input logic t, input logic [1:0] h, input logic r,
        input logic u, input logic [4:0] s, input logic [3:0] yf, input logic [5:0] yc, input logic [3:0] xf,
        input logic [5:0] xc);
        return {m, t, h, r, u, s, yf, yc, xf, xc};
    endfunction

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // one request; the answer stands for the one cycle after the taking edge
    task automatic send(input logic [31:0] w, input logic rej);
        @(posedge sys_clk);
        req_valid <= 1'h1;
        req_word <= w;
        @(posedge sys_clk);
        req_valid <= 1'h0;
        #1;
        chk(rejected, rej);
        chk(link.cmd_valid, !rej);
    endtask

    task automatic idle();
        int k;
        k = 0;
        while (busy !== 1'h0 && k < 100) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
    endtask

    task automatic pulse_continue();
        @(posedge sys_clk);
        req_continue <= 1'h1;
        star_present <= 1'h0;
        @(posedge sys_clk);
        req_continue <= 1'h0;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask

    task automatic wait_mag(output int c);
        c = 0;
        do begin
            @(posedge sys_clk);
            #1;
            c++;
        end while (mag_refresh !== 1'h1 && c < 100);
    endtask

    task automatic give_verdict();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        link2.cmd_valid = 1'h0;
        link2.serial_command_word = 32'h0000_0000;
        link2.continue_search = 1'h0;
        // search, camera map only, camera code 11 with tracking, then primary keeping te and threshold
        rows[0] = '{mk(2'h1, 1'h1, 2'h1, 1'h1, 1'h0, 5'h02, 4'h6, 6'h3e, 4'h5, 6'h03), 8'h35};
        rows[1] = '{mk(2'h2, 1'h0, 2'h2, 1'h0, 1'h1, 5'h00, 4'h1, 6'h05, 4'h2, 6'h3b), 8'h4a};
        rows[2] = '{mk(2'h3, 1'h1, 2'h3, 1'h0, 1'h0, 5'h01, 4'h9, 6'h1f, 4'ha, 6'h21), 8'h53};
        rows[3] = '{mk(2'h0, 1'h0, 2'h0, 1'h1, 1'h1, 5'h05, 4'h7, 6'h00, 4'h7, 6'h01), 8'h1f};
        repeat (2) @(posedge sys_clk);
        #1;
        chk(settings, 8'h00);
        chk(defl_x, 8'h00);
        @(posedge sys_clk);
        resetn <= 1'h1;
        for (int i = 0; i < 4; i++) begin
            idle();
            send(rows[i].w, 1'h0);
            repeat (3) @(posedge sys_clk);
            #1;
            chk(settings, rows[i].e);
            chk(8'(fine_x), 8'(rows[i].w[9:6]));
            chk(8'(fine_y), 8'(rows[i].w[19:16]));
            chk(defl_x, {{2{rows[i].w[5]}}, rows[i].w[5:0]});
            chk(defl_y, {{2{rows[i].w[15]}}, rows[i].w[15:10]});
        end
        idle();
        send(mk(2'h1, 1'h0, 2'h0, 1'h0, 1'h0, 5'h02, 4'h0, 6'h00, 4'h0, 6'h20), 1'h1);
        send(mk(2'h1, 1'h0, 2'h0, 1'h0, 1'h0, 5'h02, 4'h0, 6'h00, 4'h3, 6'h00), 1'h0);
        send(mk(2'h1, 1'h0, 2'h0, 1'h0, 1'h0, 5'h02, 4'h0, 6'h00, 4'h3, 6'h00), 1'h1);
        pulse_continue();
        chk(defl_y, 8'hfe);
        idle();
        send(mk(2'h1, 1'h0, 2'h0, 1'h0, 1'h0, 5'h02, 4'h0, 6'h05, 4'hc, 6'h07), 1'h0);
        repeat (3) @(posedge sys_clk);
        #1;
        chk(8'(fine_x), 8'h0c);
        chk(defl_y, 8'hfe);
        wait_mag(n);
        wait_mag(n);
        chk(8'(n), 8'(DWL));
        @(posedge sys_clk);
        star_present <= 1'h1;
        n = 0;
        while (tracking !== 1'h1 && n < 60) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk(tracking, 1'h1);
        pulse_continue();
        chk(tracking, 1'h0);
        idle();
        send(mk(2'h2, 1'h0, 2'h0, 1'h0, 1'h0, 5'h00, 4'h0, 6'h04, 4'h0, 6'h06), 1'h0);
        // first frame strobe only once the camera mode is in force
        @(posedge sys_clk);
        n = 0;
        e = 0;
        repeat (3) begin
            @(posedge sys_clk);
            tlm_frame <= 1'h1;
            @(posedge sys_clk);
            tlm_frame <= 1'h0;
            repeat (3) begin
                #1;
                n += mag_refresh;
                e += end_of_scan_line;
                @(posedge sys_clk);
            end
        end
        #1;
        chk(8'(n), 8'h03);
        chk(8'(e), 8'h03);
        chk(defl_x, 8'h06);
        chk(defl_y, 8'h04);
        @(posedge sys_clk);
        link2.cmd_valid <= 1'h1;
        link2.serial_command_word <= mk(2'h1, 1'h0, 2'h0, 1'h0, 1'h0, 5'h00, 4'h0, 6'h20, 4'h0, 6'h20);
        @(posedge sys_clk);
        link2.cmd_valid <= 1'h0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk(defl_x_b, tracker_cmd_pkg::DEFL_LIMIT);
        chk(defl_y_b, tracker_cmd_pkg::DEFL_LIMIT);
        give_verdict();
    end
endmodule // tracker_mode_command_setup_tb_top
